/* bench/ulpi_link_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************
// Link controller model
// ****************
module ulpi_link_model (
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       rst_n,
    // Bench controls
    input wire logic       wake_req,
    input wire logic       abort,
    input wire logic [7:0] tx_byte,
    // ULPI pins
    input wire logic       dir,
    output logic           stp,
    output logic [7:0]     data_in
);
    logic dir_q;
    // Stop high from reset; held until dir drops unless aborted
    always_ff @(posedge clk_sys or negedge rst_n)
        if (!rst_n)
            stp <= 1'b1;
        else
            stp <= !abort && (wake_req || (stp && dir));
    // Turnaround tracking
    always_ff @(posedge clk_sys or negedge rst_n)
        if (!rst_n)
            dir_q <= 1'b1;
        else
            dir_q <= dir;
    // Released bus reads low through the weak pull-downs
    assign data_in = (!dir && !dir_q) ? tx_byte : 8'h00;
endmodule
`default_nettype wire

/* bench/ulpi_low_power_tb.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************
// Bench top
// ****************
module ulpi_low_power_tb;
    localparam int TS = 20;
    localparam int TF = 8;
    logic        clk_sys, rst_n, hwrite, hready, dir, stp, oe_n, dp, dm, crst_n;
    logic        lce, vpe, sepe, pue, txv, wake_req, abort, hresp, nxt;
    logic [1:0]  htrans, opm;
    logic [3:0]  lv, re, fe, samp;
    logic [7:0]  din, dout, txb, tx_byte, b;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [2:0]  watch;
    int          n_fail, samples_checked, i;
    assign watch = {txv, dir, lce};
    ulpi_low_power #(.T_START_CYC(TS), .T_FAST_CYC(TF)) u_ulpi_low_power (
        .clk_sys(clk_sys), .rst_n(rst_n), .ce(1'b1), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .stp(stp), .dir(dir), .nxt(nxt),
        .phy_clock_output(), .data_in(din), .data_out(dout), .data_oe_n(oe_n),
        .dp_rx(dp), .dm_rx(dm), .vbus_valid_comparator(lv[0]),
        .session_valid_comparator(lv[1]), .session_end_comparator(lv[2]),
        .id_ground_comparator(lv[3]), .chip_reset_n(crst_n), .low_current_en(lce),
        .vbus_comp_power_en(vpe), .sess_end_comp_power_en(sepe), .stp_pullup_en(pue),
        .xcvr_opmode(opm), .txcmd_valid(txv), .txcmd_byte(txb));
    ulpi_link_model u_ulpi_link_model (.clk_sys(clk_sys), .rst_n(rst_n),
        .wake_req(wake_req), .abort(abort), .tx_byte(tx_byte), .dir(dir), .stp(stp),
        .data_in(din));
    // Clock
    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One single AHB transfer, wait states honoured
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        htrans <= 2'h2;
        haddr  <= {24'h0000_00, a};
        hwrite <= wr;
        do @(posedge clk_sys); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_sys); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    // Bounded wait on lce, dir or txv
    task automatic wt(input int s, input logic v);
        i = 0;
        while (watch[s] !== v && i < 500)
        begin
            @(posedge clk_sys);
            #1;
            i++;
        end
        if (i >= 500)
        begin
            n_fail++;
            complete_run();
        end
    endtask
    function automatic logic exp_int(input logic [3:0] l, s, r, f);
        return |((r & l & ~s) | (f & ~l & s));
    endfunction
    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Watchdog
    initial
    begin
        #(20000 * 100);
        n_fail++;
        complete_run();
    end
    // Main sequence
    initial
    begin
        {rst_n, hwrite, dp, dm, wake_req, abort, htrans, lv} = '0;
        {haddr, hwdata, tx_byte, n_fail, samples_checked} = '0;
        crst_n = 1'b1;
        void'($urandom(79));
        lv = 4'($urandom);
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int k = 0; k < 24; k += 4)
        begin
            bus(0, k[7:0], $urandom);
            chk(rd, k == 0 ? 32'h0000_0040 : k == 20 ? 32'(lv) : 32'h0000_0000);
            chk({hresp, nxt}, 2'h0);
        end
        chk(pue, 1'b1);
        crst_n <= 1'b0;
        #1;
        chk(pue, 1'b0);
        @(posedge clk_sys);
        crst_n <= 1'b1;
        bus(1, 8'h04, 32'h0000_0080);
        #1;
        chk(pue, 1'b0);
        $display("registers done");
        for (int p = 0; p < 2; p++)
        begin
            re = 4'($urandom);
            fe = 4'($urandom);
            bus(1, 8'h08, {28'h0000_000, re});
            bus(1, 8'h0C, {28'h0000_000, fe});
            bus(1, 8'h10, {31'h0000_0000, p[0]});
            chk(vpe, re[0] | fe[0]);
            chk(sepe, re[2] | fe[2]);
            samp = lv;
            bus(1, 8'h00, 32'h0000_0008);
            wt(0, 1);
            chk({dir, oe_n, opm}, 4'h9);
            repeat (8)
            begin
                @(posedge clk_sys);
                lv <= 4'($urandom);
                {dp, dm} <= 2'($urandom);
                #1;
                chk(dout, {4'h0, exp_int(lv, samp, re, fe), 1'b0, dm, dp});
            end
            @(posedge clk_sys);
            wake_req <= 1'b1;
            @(posedge clk_sys);
            wake_req <= 1'b0;
            if (p == 0)
            begin
                repeat (4) @(posedge clk_sys);
                abort <= 1'b1;
                @(posedge clk_sys);
                abort <= 1'b0;
                wt(0, 1);
                chk({lce, dir}, 2'h3);
                @(posedge clk_sys);
                wake_req <= 1'b1;
                @(posedge clk_sys);
                wake_req <= 1'b0;
            end
            wt(1, 0);
            chk({oe_n, i >= (p ? TF : TS), i < (p ? TS : 200)}, 3'h7);
            bus(0, 8'h00, $urandom);
            chk(rd, 32'h0000_0048);
            b = 8'($urandom);
            b[6] = 1'b1;
            tx_byte <= b;
            wt(2, 1);
            chk(txb, b);
            @(posedge clk_sys);
            tx_byte <= 8'h00;
            $display("low power pass %0d done", p);
        end
        complete_run();
    end
endmodule
`default_nettype wire

/* bench/ulpi_lp_checker.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************
// Port checker
// ****************
module ulpi_lp_checker (
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       rst_n,
    // Watched pins
    input wire logic       stp,
    input wire logic       dir,
    input wire logic       data_oe_n,
    input wire logic [7:0] data_out,
    input wire logic [7:0] data_in,
    input wire logic       dp_rx,
    input wire logic       dm_rx,
    input wire logic       phy_clock_output,
    input wire logic       low_current_en,
    input wire logic       chip_reset_n,
    input wire logic       stp_pullup_en,
    input wire logic       txcmd_valid,
    input wire logic [7:0] txcmd_byte
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic [2:0] edges_q;
    logic       pclk_q;
    // Previous clock output level
    always_ff @(posedge clk_sys or negedge rst_n)
        if (!rst_n)
            pclk_q <= 1'b0;
        else
            pclk_q <= phy_clock_output;
    // Output clock edges while dir high; saturates so it never wraps
    always_ff @(posedge clk_sys or negedge rst_n)
        if (!rst_n)
            edges_q <= 3'h0;
        else if (!dir)
            edges_q <= 3'h0;
        else if (phy_clock_output && !pclk_q && edges_q != 3'h7)
            edges_q <= edges_q + 3'h1;
    AST_BUS_MAP: assert property (!data_oe_n |-> data_out[7:4] == 4'h0 && !data_out[2]
        && data_out[1:0] == {dm_rx, dp_rx}) else $error("low power bus map wrong");
    AST_BUS_QUIET: assert property (data_oe_n |-> data_out == 8'h00)
        else $error("data out not quiet");
    AST_ENTRY_EDGES: assert property ($rose(low_current_en) |-> edges_q >= 3'h5)
        else $error("too few clock edges");
    AST_CLK_STOPPED: assert property (low_current_en |-> !phy_clock_output && dir)
        else $error("low current with clock live");
    AST_TURNAROUND: assert property ($rose(dir) |-> data_oe_n ##1 !data_oe_n)
        else $error("no turnaround after dir rise");
    AST_DIR_RELEASE: assert property ($fell(dir) |-> data_oe_n)
        else $error("bus driven after dir fall");
    AST_WAKE: assert property (low_current_en && stp |=> !low_current_en)
        else $error("stop ignored in low power");
    AST_PULLUP_OFF: assert property (!chip_reset_n |-> !stp_pullup_en)
        else $error("pull-up on in chip reset");
    AST_TXCMD: assert property (txcmd_valid |-> $past(data_in[7:6]) != 2'h0
        && txcmd_byte == $past(data_in)) else $error("command byte wrong");
    // Main scenarios reached
    cover property ($rose(low_current_en));
    cover property ($fell(dir));
    cover property (txcmd_valid);
    cover property (data_out[3]);
endmodule

bind ulpi_low_power ulpi_lp_checker u_ulpi_lp_checker (.clk_sys(clk_sys), .rst_n(rst_n),
    .stp(stp), .dir(dir), .data_oe_n(data_oe_n), .data_out(data_out), .data_in(data_in),
    .dp_rx(dp_rx), .dm_rx(dm_rx), .phy_clock_output(phy_clock_output),
    .low_current_en(low_current_en), .chip_reset_n(chip_reset_n),
    .stp_pullup_en(stp_pullup_en), .txcmd_valid(txcmd_valid), .txcmd_byte(txcmd_byte));
`default_nettype wire

/* design/event_counter.sv */
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Counter of enabled events against a limit
// ****************************************************************
module event_counter #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire logic         ce,
    // Control
    input  wire logic         clear,
    input  wire logic         count_en,
    input  wire logic [W-1:0] limit,
    // Result
    output logic              done
);

    logic [W-1:0] count_q;

    // Count saturates at the limit so a long wait cannot wrap
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            count_q <= '0;
        else if (ce)
        begin
            if (clear)
                count_q <= '0;
            else if (count_en && !done)
                count_q <= count_q + 1'b1;
        end
    end

    // Reached the limit
    assign done = (count_q >= limit);

endmodule

`default_nettype wire

/* design/irq_source.sv */
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// One interrupt source: sampled level against live level
// ****************************************************************
module irq_source (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic ce,
    // Source and enables
    input  wire logic level,
    input  wire logic sample_en,
    input  wire logic rise_en,
    input  wire logic fall_en,
    input  wire logic armed,
    // Result
    output logic      flag
);

    logic sampled_q;

    // Reference level, caught as the bus turns toward the device
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            sampled_q <= 1'b0;
        else if (ce && sample_en)
            sampled_q <= level;
    end

    // No clock in this path: must work while every clock is stopped
    assign flag = armed & ((rise_en & level & ~sampled_q) | (fall_en & ~level & sampled_q));

endmodule

`default_nettype wire

/* design/ulpi_low_power.sv */
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - After that write, raise DIR, then five clock output rising edges, then hold low.
// - Low current state only once the clock output has stopped.
// - Low power bus map: line state bits 1:0, interrupt bit 3, rest low.
// - Line state follows DP and DM receivers combinationally.
// - Enabled comparator change in low power raises data bit 3.
// - Low power data bus driven without any clock.
// - STP high wakes; start-up, clock restart, then DIR drops.
// - Device sets phy active bit itself on wake.
// - STP falling before DIR drops is a false resume; back to low power.
// - Bus driven by DIR owner; one turnaround cycle undriven after each change.
// - Link drives idle after each receive command turnaround.
// - A leftover value on the bus after DIR falls is taken as a command.
// - STP pull-up on at reset, off when protect disable bit set.
// - Any STP high in low power is a wake request.
// - VBUS valid and session end comparators powered down when both their interrupt enables are clear.
// - STP pull-up off while chip reset is low.
module ulpi_low_power #(
    parameter int T_START_CYC = ulpi_lp_pkg::T_START_US * ulpi_lp_pkg::CLK_MHZ,
    parameter int T_FAST_CYC  = ulpi_lp_pkg::T_START_FAST_US * ulpi_lp_pkg::CLK_MHZ
) (
    // Clock, reset, enable
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // ULPI link side
    input  wire logic        stp,
    output logic             dir,
    output logic             nxt,
    output logic             phy_clock_output,
    input  wire logic [7:0]  data_in,
    output logic [7:0]  data_out,
    output logic             data_oe_n,
    // Analog front end
    input  wire logic        dp_rx,
    input  wire logic        dm_rx,
    input  wire logic        vbus_valid_comparator,
    input  wire logic        session_valid_comparator,
    input  wire logic        session_end_comparator,
    input  wire logic        id_ground_comparator,
    input  wire logic        chip_reset_n,
    output logic             low_current_en,
    output logic             vbus_comp_power_en,
    output logic             sess_end_comp_power_en,
    output logic             stp_pullup_en,
    output logic [1:0]       xcvr_opmode,
    // Accepted transmit command
    output logic             txcmd_valid,
    output logic [7:0]       txcmd_byte
);

    // ****************************************************************
    // Register bus
    // ****************************************************************
    ulpi_lp_pkg::lp_state_e state_q;
    ulpi_lp_pkg::lp_state_e state_d;

    logic [7:0] func_ctrl_q;
    logic [7:0] iface_ctrl_q;
    logic [3:0] irq_rise_en_q;
    logic [3:0] irq_fall_en_q;
    logic [7:0] hs_comp_q;
    logic       wr_pend_q;
    logic [7:0] wr_addr_q;
    logic       addr_take;
    logic       wr_func;
    logic       wake_done;
    logic [3:0] src_level;
    logic [3:0] src_flag;
    logic       int_flag;

    // Stall the master while frozen rather than lose a transfer
    assign hreadyout = ce;
    assign hresp     = 1'b0;
    assign addr_take = hsel & hready & htrans[ulpi_lp_pkg::HTRANS_ACT_POS];

    // Address phase of a write
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end
        else if (ce)
        begin
            wr_pend_q <= addr_take & hwrite;
            wr_addr_q <= haddr[7:0];
        end
    end

    assign wr_func = wr_pend_q && (wr_addr_q == ulpi_lp_pkg::FUNC_CTRL_OFS);

    // Function control; the wake-up set wins over a write in the same cycle
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            func_ctrl_q <= ulpi_lp_pkg::FUNC_CTRL_RST;
        else if (ce)
        begin
            if (wr_func)
                func_ctrl_q <= hwdata[7:0];
            if (wake_done)
                func_ctrl_q[ulpi_lp_pkg::PHY_ACTIVE_POS] <= 1'b1;
        end
    end

    // Other writable registers
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            iface_ctrl_q  <= ulpi_lp_pkg::IFACE_CTRL_RST;
            irq_rise_en_q <= ulpi_lp_pkg::IRQ_EN_RST;
            irq_fall_en_q <= ulpi_lp_pkg::IRQ_EN_RST;
            hs_comp_q     <= ulpi_lp_pkg::HS_COMP_RST;
        end
        else if (ce && wr_pend_q)
        begin
            unique case (wr_addr_q)
                ulpi_lp_pkg::IFACE_CTRL_OFS: iface_ctrl_q  <= hwdata[7:0];
                ulpi_lp_pkg::IRQ_RISE_OFS:   irq_rise_en_q <= hwdata[3:0];
                ulpi_lp_pkg::IRQ_FALL_OFS:   irq_fall_en_q <= hwdata[3:0];
                ulpi_lp_pkg::HS_COMP_OFS:    hs_comp_q     <= hwdata[7:0];
                default:                     ;
            endcase
        end
    end

    // Read data registered in the address phase; unmapped reads give zero
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            hrdata <= 32'h0000_0000;
        else if (ce && addr_take && !hwrite)
        begin
            unique case (haddr[7:0])
                ulpi_lp_pkg::FUNC_CTRL_OFS:  hrdata <= {24'h00_0000, func_ctrl_q};
                ulpi_lp_pkg::IFACE_CTRL_OFS: hrdata <= {24'h00_0000, iface_ctrl_q};
                ulpi_lp_pkg::IRQ_RISE_OFS:   hrdata <= {28'h000_0000, irq_rise_en_q};
                ulpi_lp_pkg::IRQ_FALL_OFS:   hrdata <= {28'h000_0000, irq_fall_en_q};
                ulpi_lp_pkg::HS_COMP_OFS:    hrdata <= {24'h00_0000, hs_comp_q};
                ulpi_lp_pkg::STATUS_OFS:     hrdata <= {21'h00_0000, state_q, int_flag,
                                                        dir, low_current_en, 1'b0, src_level};
                default:                     hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // ****************************************************************
    // Power state machine
    // ****************************************************************
    logic       clk_out_q;
    logic       clk_run;
    logic       rise_pulse;
    logic       edges_done;
    logic       start_done;
    localparam int CNT_W_L = ulpi_lp_pkg::CNT_W;
    logic       seq_clear;
    logic [CNT_W_L-1:0] edge_limit;
    logic [CNT_W_L-1:0] start_limit;

    // Clock output edges to run before stopping or before releasing DIR
    assign edge_limit = (state_q == ulpi_lp_pkg::ST_RESTART) ?
                        CNT_W_L'(ulpi_lp_pkg::RESTART_EDGES) :
                        CNT_W_L'(ulpi_lp_pkg::ENTRY_EDGES);
    // Shorter start-up under fast recovery
    assign start_limit = hs_comp_q[ulpi_lp_pkg::FAST_REC_POS] ?
                         CNT_W_L'(T_FAST_CYC) : CNT_W_L'(T_START_CYC);

    // Next state
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ulpi_lp_pkg::ST_ACTIVE:
                if (wr_func && !hwdata[ulpi_lp_pkg::PHY_ACTIVE_POS])
                    state_d = ulpi_lp_pkg::ST_ENTRY;
            ulpi_lp_pkg::ST_ENTRY:
                if (edges_done && !clk_out_q)
                    state_d = ulpi_lp_pkg::ST_LOW_POWER;
            ulpi_lp_pkg::ST_LOW_POWER:
                if (stp)
                    state_d = ulpi_lp_pkg::ST_STARTUP;
            ulpi_lp_pkg::ST_STARTUP:
                if (!stp)
                    state_d = ulpi_lp_pkg::ST_LOW_POWER;
                else if (start_done)
                    state_d = ulpi_lp_pkg::ST_RESTART;
            ulpi_lp_pkg::ST_RESTART:
                if (!stp)
                    state_d = ulpi_lp_pkg::ST_ENTRY;
                else if (edges_done && rise_pulse)
                    state_d = ulpi_lp_pkg::ST_ACTIVE;
            default:
                state_d = ulpi_lp_pkg::ST_ACTIVE;
        endcase
    end

    // State register
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            state_q <= ulpi_lp_pkg::ST_ACTIVE;
        else if (ce)
            state_q <= state_d;
    end

    assign wake_done = (state_q == ulpi_lp_pkg::ST_RESTART) &&
                       (state_d == ulpi_lp_pkg::ST_ACTIVE);
    assign seq_clear = (state_q != state_d);

    // Clock output runs when active, during entry until the count is met, and on restart
    assign clk_run    = (state_q == ulpi_lp_pkg::ST_ACTIVE) ||
                        (state_q == ulpi_lp_pkg::ST_RESTART) ||
                        ((state_q == ulpi_lp_pkg::ST_ENTRY) && !edges_done);
    assign rise_pulse = clk_run & ~clk_out_q;

    // Divided clock output; parks low once stopped
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            clk_out_q <= 1'b0;
        else if (ce)
        begin
            if (clk_run)
                clk_out_q <= ~clk_out_q;
            else
                clk_out_q <= 1'b0;
        end
    end

    // Rising edges of the clock output
    event_counter #(.W(CNT_W_L)) u_edges (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .ce       (ce),
        .clear    (seq_clear),
        .count_en (rise_pulse),
        .limit    (edge_limit),
        .done     (edges_done)
    );

    // Start-up delay
    event_counter #(.W(CNT_W_L)) u_start (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .ce       (ce),
        .clear    (seq_clear),
        .count_en (state_q == ulpi_lp_pkg::ST_STARTUP),
        .limit    (start_limit),
        .done     (start_done)
    );

    // ****************************************************************
    // ULPI bus ownership and low power data map
    // ****************************************************************
    logic dir_q;
    logic drive_q;
    logic dir_prev_q;

    // DIR high in every state but active; bus driven one cycle later
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dir_q      <= 1'b0;
            drive_q    <= 1'b0;
            dir_prev_q <= 1'b0;
        end
        else if (ce)
        begin
            dir_q      <= (state_d != ulpi_lp_pkg::ST_ACTIVE);
            drive_q    <= dir_q & (state_d != ulpi_lp_pkg::ST_ACTIVE);
            dir_prev_q <= dir_q;
        end
    end

    assign dir              = dir_q;
    assign nxt              = 1'b0;
    assign phy_clock_output = clk_out_q;
    assign data_oe_n        = ~drive_q;

    // Clockless map from receivers and flag straight to the pins
    always_comb
    begin
        data_out = 8'h00;
        if (drive_q)
        begin
            data_out[ulpi_lp_pkg::LS_DP_POS]    = dp_rx;
            data_out[ulpi_lp_pkg::LS_DM_POS]    = dm_rx;
            data_out[ulpi_lp_pkg::INT_FLAG_POS] = int_flag;
        end
    end

    // ****************************************************************
    // Comparator interrupts and power controls
    // ****************************************************************
    assign src_level = {id_ground_comparator, session_end_comparator,
                        session_valid_comparator, vbus_valid_comparator};

    genvar gi;
    generate
        for (gi = 0; gi < ulpi_lp_pkg::NUM_SRC; gi++)
        begin : g_src
            irq_source u_src (
                .clk_sys   (clk_sys),
                .rst_n     (rst_n),
                .ce        (ce),
                .level     (src_level[gi]),
                .sample_en (seq_clear && (state_d == ulpi_lp_pkg::ST_ENTRY)),
                .rise_en   (irq_rise_en_q[gi]),
                .fall_en   (irq_fall_en_q[gi]),
                .armed     (state_q == ulpi_lp_pkg::ST_LOW_POWER),
                .flag      (src_flag[gi])
            );
        end
    endgenerate

    assign int_flag = |src_flag;

    // Comparator off only when both enables are clear
    assign vbus_comp_power_en     = irq_rise_en_q[ulpi_lp_pkg::SRC_VBUS_VALID] |
                                    irq_fall_en_q[ulpi_lp_pkg::SRC_VBUS_VALID];
    assign sess_end_comp_power_en = irq_rise_en_q[ulpi_lp_pkg::SRC_SESS_END] |
                                    irq_fall_en_q[ulpi_lp_pkg::SRC_SESS_END];

    // Pull-up gated directly by the chip reset pin, no clock involved
    assign stp_pullup_en  = chip_reset_n &
                            ~iface_ctrl_q[ulpi_lp_pkg::PROTECT_DIS_POS];
    assign low_current_en = (state_q == ulpi_lp_pkg::ST_LOW_POWER);
    assign xcvr_opmode    = func_ctrl_q[ulpi_lp_pkg::OPMODE_LSB +: 2];

    // ****************************************************************
    // Command capture while the link owns the bus
    // ****************************************************************
    // Any non-idle byte after turnaround is taken, leftover or not
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            txcmd_valid <= 1'b0;
            txcmd_byte  <= 8'h00;
        end
        else if (ce)
        begin
            txcmd_valid <= (state_q == ulpi_lp_pkg::ST_ACTIVE) && !dir_q && !dir_prev_q &&
                           !stp && (data_in[7:ulpi_lp_pkg::CMD_TYPE_LSB] != 2'b00);
            txcmd_byte  <= data_in;
        end
    end

endmodule

`default_nettype wire

/* design/ulpi_lp_pkg.sv */
// ****************************************************************
// Shared constants for the low power entry/exit block
// ****************************************************************
package ulpi_lp_pkg;

    // Register bus geometry
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 8;

    // Register byte offsets
    localparam logic [7:0]  FUNC_CTRL_OFS   = 8'h00;
    localparam logic [7:0]  IFACE_CTRL_OFS  = 8'h04;
    localparam logic [7:0]  IRQ_RISE_OFS    = 8'h08;
    localparam logic [7:0]  IRQ_FALL_OFS    = 8'h0C;
    localparam logic [7:0]  HS_COMP_OFS     = 8'h10;
    localparam logic [7:0]  STATUS_OFS      = 8'h14;

    // Field positions
    localparam int          PHY_ACTIVE_POS  = 6;
    localparam int          OPMODE_LSB      = 3;
    localparam int          PROTECT_DIS_POS = 7;
    localparam int          FAST_REC_POS    = 0;
    localparam int          LS_DP_POS       = 0;
    localparam int          LS_DM_POS       = 1;
    localparam int          INT_FLAG_POS    = 3;
    localparam int          CMD_TYPE_LSB    = 6;
    localparam int          HTRANS_ACT_POS  = 1;
    localparam int          ST_STATE_LSB    = 8;

    // Interrupt sources, one bit each
    localparam int          NUM_SRC         = 4;
    localparam int          SRC_VBUS_VALID  = 0;
    localparam int          SRC_SESS_VALID  = 1;
    localparam int          SRC_SESS_END    = 2;
    localparam int          SRC_ID_GROUND   = 3;

    // Reset values
    localparam logic [7:0]  FUNC_CTRL_RST   = 8'h40;
    localparam logic [7:0]  IFACE_CTRL_RST  = 8'h00;
    localparam logic [3:0]  IRQ_EN_RST      = 4'h0;
    localparam logic [7:0]  HS_COMP_RST     = 8'h00;

    // Clock output edge counts
    localparam int          ENTRY_EDGES     = 5;
    localparam int          RESTART_EDGES   = 2;

    // Start-up times and clock rate
    localparam int          CLK_MHZ         = 10;
    localparam int          T_START_US      = 1000;
    localparam int          T_START_FAST_US = 50;
    localparam int          CNT_W           = 16;

    // Power state
    typedef enum logic [2:0] {
        ST_ACTIVE    = 3'b000,
        ST_ENTRY     = 3'b001,
        ST_LOW_POWER = 3'b010,
        ST_STARTUP   = 3'b011,
        ST_RESTART   = 3'b100
    } lp_state_e;

endpackage
